//--- hdl/rdce_pkg.sv
// package of constants and types for the direct command executor
package rdce_pkg;
	// command codes (block-local encoding)
	localparam logic [3:0] CMD_SQUELCH    = 4'h1;
	localparam logic [3:0] CMD_GAIN_RESET = 4'h2;
	localparam logic [3:0] CMD_REG_ADJUST = 4'h3;
	localparam logic [3:0] CMD_CAL_MOD    = 4'h4;
	localparam logic [3:0] CMD_CAL_ANT    = 4'h5;
	localparam logic [3:0] CMD_MEAS_PHASE = 4'h6;
	localparam logic [3:0] CMD_RSSI_CLEAR = 4'h7;
	localparam logic [3:0] CMD_TRANSP     = 4'h8;
	localparam logic [3:0] CMD_CAL_CAPS   = 4'h9;
	localparam logic [3:0] CMD_MEAS_CAP   = 4'hA;
	localparam logic [3:0] CMD_MEAS_SUP   = 4'hB;
	localparam logic [3:0] CMD_TEST_ACC   = 4'hC;
	localparam logic [3:0] CMD_MEAS_AMP   = 4'hD;
	// register map (word byte addresses)
	localparam logic [3:0] ADDR_CMD    = 4'h0;
	localparam logic [3:0] ADDR_CTRL   = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_RESULT = 4'hC;
	// control register field positions
	localparam int CTRL_EN_BIT   = 7;
	localparam int CTRL_EXTREG   = 8;
	localparam int CTRL_SUP5V    = 9;
	localparam int CTRL_MPSV_LO  = 10;
	localparam int CTRL_MPSV_HI  = 11;
	localparam int CTRL_GAIN_LSB = 12;
	localparam int CTRL_MOD_LSB  = 16;
	localparam int CTRL_MCAL_LSB = 24;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// regulator setting codes in mV
	localparam logic [12:0] REG5_MAX  = 13'h13EC; // 5100
	localparam logic [12:0] REG5_MIN  = 13'h0F3C; // 3900
	localparam logic [12:0] REG5_STEP = 13'h0078; // 120
	localparam logic [12:0] REG3_MAX  = 13'h0D48; // 3400
	localparam logic [12:0] REG3_MIN  = 13'h0960; // 2400
	localparam logic [12:0] REG3_STEP = 13'h0064; // 100
	localparam logic [12:0] MARGIN_MV = 13'h00FA; // 250
	// timing
	localparam int CLK_MHZ        = 100;
	localparam int T_SQUELCH_US   = 500;
	localparam int T_REG_STEP_US  = 300;
	localparam int T_REG_MAX_US   = 5000;
	localparam int T_CALMOD_US    = 275;
	localparam int T_CALANT_US    = 250;
	localparam int T_MEAS_US      = 25;
	localparam int T_CALCAP_US    = 3000;
	localparam int T_MEASCAP_US   = 250;
	localparam int CYC_SQUELCH    = T_SQUELCH_US * CLK_MHZ;
	localparam int CYC_REG_STEP   = T_REG_STEP_US * CLK_MHZ;
	localparam int CYC_REG_MAX    = T_REG_MAX_US * CLK_MHZ;
	localparam int CYC_CALMOD     = T_CALMOD_US * CLK_MHZ;
	localparam int CYC_CALANT     = T_CALANT_US * CLK_MHZ;
	localparam int CYC_MEAS       = T_MEAS_US * CLK_MHZ;
	localparam int CYC_CALCAP     = T_CALCAP_US * CLK_MHZ;
	localparam int CYC_MEASCAP    = T_MEASCAP_US * CLK_MHZ;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_REG  = 2'b10,
		ST_DONE = 2'b11
	} rdce_state_t;
endpackage : rdce_pkg

//--- hdl/rdce_top.sv
// direct command executor with avalon-mm register slave
// Overview of operation
// (R1) squelch needs tx/rx, runs only when rx idle
// (R2) gain reset clears squelch, loads manual gain
// (R3) most commands need enable and oscillator stable
// (R4) regulator starts max, steps down every 300us
// (R5) step 120/100 mV, floor 3.9/2.4 V
// (R6) external regulator rejects adjust; irq, 5 ms
// (R7) modulation calibration writes depth back, irq
// (R8) antenna calibration sets trim pins, 250us
// (R9) phase measurement into result, 25us, irq
// (R10) phase saturates FFh low, 00h high
// (R11) phase step 0.468 degrees of carrier
// (R12) rssi cleared on rx rise or command
// (R13) transparent while select high after command
// (R14) capsense cal only when manual bits zero
// (R15) capacitance measurement 250us, irq, no chaining
// (R16) supply measurement selects one of four
// (R17) only gain reset and rssi clear chain
// (R18) irq only after long commands finish
// (R19) test access enables test registers and pins
// (R20) amplitude measurement 25us with irq
// (R21) rejected command changes nothing
`timescale 1ns/1ps
module rdce_top
	import rdce_pkg::*;
#(
	parameter int SQUELCH_CYC = CYC_SQUELCH,
	parameter int REG_STEP_CYC = CYC_REG_STEP,
	parameter int CALMOD_CYC = CYC_CALMOD,
	parameter int CALANT_CYC = CYC_CALANT,
	parameter int CALCAP_CYC = CYC_CALCAP,
	parameter int MEASCAP_CYC = CYC_MEASCAP
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// asynchronous status from the front end
	input  wire logic        osc_stable_i,
	input  wire logic        tx_on_i,
	input  wire logic        rx_en_i,
	input  wire logic        receive_active_i,
	input  wire logic        spi_select_i,
	input  wire logic        reg_ok_i,
	input  wire logic        ant_in_tune_i,
	input  wire logic [7:0]  adc_value_i,
	// analog controls and results
	output logic             irq_o,
	output logic             chain_ok_o,
	output logic [12:0]      reg_setting_o,
	output logic [5:0]       antenna_trim_pins_o,
	output logic [2:0]       adc_route_o,
	output logic             squelch_o,
	output logic             rssi_clear_o,
	output logic             transparent_o,
	output logic             test_access_o,
	output logic             test_observe_pin_a_o,
	output logic             test_observe_pin_b_o
);
	rdce_state_t state_q;
	logic [31:0] ctrl_q;
	logic [7:0]  result_q;
	logic [7:0]  gain_q;
	logic [3:0]  cmd_q;
	logic [18:0] cnt_q;
	logic [18:0] tot_q;
	logic        irq_q;
	logic        transp_arm_q;
	logic        sel_prev_q;
	logic        act_prev_q;
	logic [12:0] reg_q;
	logic [5:0]  trim_q;
	logic [14:0] s1_q;
	logic [14:0] s2_q;
	logic [7:0]  adc1_q;
	logic [7:0]  adc_q;
	logic osc_s, tx_s, rx_s, act_s, sel_s, regok_s, tune_s;
	logic wr, rd, wcmd, accept, gated, sup5;
	logic rd_wait_q, rd_take;

	assign sup5 = ctrl_q[CTRL_SUP5V];
	// two flop synchronisers for every front-end input
	always_ff @(posedge ref_clk_i) begin
		s1_q <= {osc_stable_i, tx_on_i, rx_en_i, receive_active_i, spi_select_i,
			reg_ok_i, ant_in_tune_i, 8'h00};
		s2_q <= s1_q;
		adc1_q <= adc_value_i;
		adc_q <= adc1_q;
	end
	assign {osc_s, tx_s, rx_s, act_s, sel_s, regok_s, tune_s} = s2_q[14:8];

	// bus decode, one wait state on reads so read data stand when taken
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rd_wait_q <= 1'b0;
		end else begin
			rd_wait_q <= avs_read_i && !rd_wait_q;
		end
	end
	assign avs_waitrequest_o = avs_read_i && !rd_wait_q;
	assign wr = avs_write_i;
	assign rd = avs_read_i;
	assign rd_take = rd && rd_wait_q; // read completes at this edge
	assign wcmd = wr && (avs_address_i == ADDR_CMD);
	assign gated = ctrl_q[CTRL_EN_BIT] && osc_s; // [R3]

	// acceptance check per command
	function automatic logic ok_cmd(input logic [3:0] c, input logic g, input logic e,
		input logic t, input logic r, input logic [7:0] m);
		unique case (c)
			CMD_SQUELCH:    ok_cmd = t && r; // [R1]
			CMD_REG_ADJUST: ok_cmd = g && !e; // [R6]
			CMD_CAL_CAPS:   ok_cmd = (m == 8'h00); // [R14]
			CMD_MEAS_CAP, CMD_TEST_ACC: ok_cmd = 1'b1;
			CMD_GAIN_RESET, CMD_CAL_MOD, CMD_CAL_ANT, CMD_MEAS_PHASE,
			CMD_RSSI_CLEAR, CMD_TRANSP, CMD_MEAS_SUP, CMD_MEAS_AMP: ok_cmd = g; // [R3]
			default:        ok_cmd = 1'b0; // [R21]
		endcase
	endfunction : ok_cmd

	// duration of a timed command in cycles
	function automatic logic [18:0] dur(input logic [3:0] c);
		unique case (c)
			CMD_SQUELCH:  dur = 19'(SQUELCH_CYC);
			CMD_CAL_MOD:  dur = 19'(CALMOD_CYC);
			CMD_CAL_ANT:  dur = 19'(CALANT_CYC);
			CMD_CAL_CAPS: dur = 19'(CALCAP_CYC);
			CMD_MEAS_CAP: dur = 19'(MEASCAP_CYC);
			default:      dur = 19'(CYC_MEAS);
		endcase
	endfunction : dur

	// a gain reset may also break into a running squelch
	assign accept = wcmd && (state_q == ST_IDLE
		|| (state_q == ST_RUN && cmd_q == CMD_SQUELCH
		&& avs_writedata_i[3:0] == CMD_GAIN_RESET))
		&& ok_cmd(avs_writedata_i[3:0], gated, ctrl_q[CTRL_EXTREG], tx_s, rx_s,
			ctrl_q[CTRL_MCAL_LSB +: 8]);

	// control register
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr && avs_address_i == ADDR_CTRL) begin
			ctrl_q <= avs_writedata_i;
		end else if (state_q == ST_DONE && cmd_q == CMD_CAL_MOD) begin
			ctrl_q[CTRL_MOD_LSB +: 8] <= adc_q; // [R7]
		end
	end

	// sequencer
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			cmd_q <= 4'h0;
			cnt_q <= 19'h0;
			tot_q <= 19'h0;
			reg_q <= REG3_MAX;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (accept) begin
						cmd_q <= avs_writedata_i[3:0];
						cnt_q <= dur(avs_writedata_i[3:0]);
						tot_q <= 19'h0;
						if (avs_writedata_i[3:0] == CMD_REG_ADJUST) begin
							reg_q <= sup5 ? REG5_MAX : REG3_MAX; // [R4]
							cnt_q <= 19'(REG_STEP_CYC);
							state_q <= ST_REG;
						end else if (avs_writedata_i[3:0] == CMD_SQUELCH
							|| avs_writedata_i[3:0] == CMD_CAL_MOD
							|| avs_writedata_i[3:0] == CMD_CAL_ANT
							|| avs_writedata_i[3:0] == CMD_MEAS_PHASE
							|| avs_writedata_i[3:0] >= CMD_CAL_CAPS
							&& avs_writedata_i[3:0] != CMD_TEST_ACC) begin
							state_q <= ST_RUN;
						end
					end
				end
				ST_RUN: begin
					cnt_q <= cnt_q - 19'h1;
					// squelch aborts when receive activity appears [R1]
					if (cnt_q == 19'h1 || (cmd_q == CMD_SQUELCH && act_s)) begin
						state_q <= ST_DONE;
					end
					// antenna finishes early once tank resonates [R8]
					if (cmd_q == CMD_CAL_ANT && tune_s) begin
						state_q <= ST_DONE;
					end
					// gain reset stops the squelch, no irq [R2]
					if (accept) begin
						cmd_q <= CMD_GAIN_RESET;
						state_q <= ST_IDLE;
					end
				end
				ST_REG: begin
					cnt_q <= cnt_q - 19'h1;
					tot_q <= tot_q + 19'h1;
					if (cnt_q == 19'h1) begin
						cnt_q <= 19'(REG_STEP_CYC);
						// step down while margin missing [R4] [R5]
						if (regok_s || reg_q <= (sup5 ? REG5_MIN : REG3_MIN)) begin
							state_q <= ST_DONE;
						end else begin
							reg_q <= reg_q - (sup5 ? REG5_STEP : REG3_STEP);
						end
					end
					if (tot_q >= 19'(CYC_REG_MAX - 1)) begin
						state_q <= ST_DONE; // [R6]
					end
				end
				ST_DONE: state_q <= ST_IDLE;
			endcase
		end
	end

	// antenna trim walks until resonance
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			trim_q <= 6'h00;
		end else if (state_q == ST_RUN && cmd_q == CMD_CAL_ANT && !tune_s) begin
			trim_q <= trim_q + 6'h01; // [R8]
		end
	end

	// result register from converter
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			result_q <= 8'h00;
		end else if (state_q == ST_DONE && (cmd_q == CMD_MEAS_PHASE
			|| cmd_q == CMD_MEAS_SUP || cmd_q == CMD_MEAS_AMP)) begin
			result_q <= adc_q; // [R9] [R10] [R11] [R16] [R20]
		end
	end

	// completion interrupt, set wins over read clear
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_q <= 1'b0;
		end else if (state_q == ST_DONE && cmd_q != CMD_SQUELCH) begin
			irq_q <= 1'b1; // [R18] [R15]
		end else if (rd_take && avs_address_i == ADDR_STATUS) begin
			irq_q <= 1'b0;
		end
	end

	// gain, transparent, rssi, test access
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			gain_q <= 8'h00;
			transp_arm_q <= 1'b0;
			sel_prev_q <= 1'b0;
			act_prev_q <= 1'b0;
			rssi_clear_o <= 1'b0;
			test_access_o <= 1'b0;
			transparent_o <= 1'b0;
		end else begin
			sel_prev_q <= sel_s;
			act_prev_q <= act_s;
			rssi_clear_o <= (act_s && !act_prev_q)
				|| (accept && avs_writedata_i[3:0] == CMD_RSSI_CLEAR); // [R12]
			if (accept && avs_writedata_i[3:0] == CMD_GAIN_RESET) begin
				gain_q <= {4'h0, ctrl_q[CTRL_GAIN_LSB +: 4]}; // [R2]
			end
			if (accept && avs_writedata_i[3:0] == CMD_TEST_ACC) begin
				test_access_o <= 1'b1; // [R19]
			end
			if (accept && avs_writedata_i[3:0] == CMD_TRANSP) begin
				transp_arm_q <= 1'b1;
			end
			if (transp_arm_q && sel_s && !sel_prev_q) begin
				transparent_o <= 1'b1; // [R13]
				transp_arm_q <= 1'b0;
			end else if (!sel_s) begin
				transparent_o <= 1'b0; // [R13]
			end
		end
	end

	// read data mux
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			avs_readdata_o <= 32'h0;
		end else if (rd && !rd_wait_q) begin
			unique case (avs_address_i)
				ADDR_CTRL:   avs_readdata_o <= ctrl_q;
				ADDR_STATUS: avs_readdata_o <= {22'h0, gain_q, state_q != ST_IDLE, irq_q};
				ADDR_RESULT: avs_readdata_o <= {24'h0, result_q};
				default:     avs_readdata_o <= 32'h0;
			endcase
		end
	end

	assign irq_o = irq_q;
	// only gain reset and rssi clear allow chaining [R17]
	assign chain_ok_o = (state_q == ST_IDLE)
		&& (cmd_q == CMD_GAIN_RESET || cmd_q == CMD_RSSI_CLEAR);
	assign reg_setting_o = reg_q;
	assign antenna_trim_pins_o = trim_q;
	assign squelch_o = (state_q == ST_RUN) && (cmd_q == CMD_SQUELCH) && !act_s; // [R1]
	assign adc_route_o = (cmd_q == CMD_MEAS_SUP)
		? {1'b1, ctrl_q[CTRL_MPSV_HI], ctrl_q[CTRL_MPSV_LO]} : 3'b000; // [R16]
	assign test_observe_pin_a_o = test_access_o && rx_s; // [R19]
	assign test_observe_pin_b_o = test_access_o && tx_s;

	AST_IRQ_AFTER_DONE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		state_q == ST_DONE && cmd_q == CMD_MEAS_PHASE |=> irq_q) // [R9]
		else $error("phase done without irq");
	AST_SQUELCH_NO_IRQ: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		state_q == ST_DONE && cmd_q == CMD_SQUELCH && !irq_q |=> !irq_q) // [R18]
		else $error("squelch raised irq");
	AST_REG_REJECT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wcmd && avs_writedata_i[3:0] == CMD_REG_ADJUST && ctrl_q[CTRL_EXTREG]
		&& state_q == ST_IDLE
		|=> state_q != ST_REG) // [R6]
		else $error("adjust accepted with external regulator");
	AST_GATED: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wcmd && !gated && avs_writedata_i[3:0] == CMD_MEAS_PHASE
		&& state_q == ST_IDLE |=> state_q == ST_IDLE) // [R3] [R21]
		else $error("command ran while disabled");
	AST_REG_FLOOR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		state_q == ST_REG |-> reg_q >= (sup5 ? REG5_MIN : REG3_MIN)) // [R5]
		else $error("regulator below floor");
	AST_REG_START: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		accept && avs_writedata_i[3:0] == CMD_REG_ADJUST
		|=> reg_q == (sup5 ? REG5_MAX : REG3_MAX)) // [R4]
		else $error("regulator not at max");
	AST_CAPS_MANUAL: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wcmd && avs_writedata_i[3:0] == CMD_CAL_CAPS && ctrl_q[CTRL_MCAL_LSB +: 8] != 8'h00
		|-> !accept) // [R14]
		else $error("capsense cal in manual mode");
	AST_CHAIN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		chain_ok_o |-> cmd_q != CMD_MEAS_CAP && cmd_q != CMD_REG_ADJUST) // [R17]
		else $error("chaining allowed wrongly");
	AST_TRANSP_DROP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		transparent_o && !sel_s |=> !transparent_o) // [R13]
		else $error("transparent held without select");
	COV_PHASE: cover property (@(posedge ref_clk_i) state_q == ST_DONE && cmd_q == CMD_MEAS_PHASE);
	COV_REG: cover property (@(posedge ref_clk_i) state_q == ST_DONE && cmd_q == CMD_REG_ADJUST);
	COV_TRANSP: cover property (@(posedge ref_clk_i) transparent_o);
	COV_SQ_ABORT: cover property (@(posedge ref_clk_i) accept && state_q == ST_RUN);
	COV_ANT: cover property (@(posedge ref_clk_i) state_q == ST_DONE && cmd_q == CMD_CAL_ANT);

	// bus, abort, rssi, result, irq, test pin, transparent and trim checks
	AST_RD_WAIT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		$rose(avs_read_i) |-> avs_waitrequest_o) // [R21]
		else $error("read taken without wait state");
	AST_GAIN_ABORT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		accept && state_q == ST_RUN |=> state_q == ST_IDLE && !squelch_o) // [R2]
		else $error("gain reset did not stop squelch");
	AST_RSSI_RISE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		act_s && !act_prev_q |=> rssi_clear_o) // [R12]
		else $error("rssi not cleared on receive start");
	AST_RESULT_LOAD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		state_q == ST_DONE && cmd_q == CMD_MEAS_SUP |=> result_q == $past(adc_q)) // [R16]
		else $error("supply result not stored");
	AST_IRQ_CLEAR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rd_take && avs_address_i == ADDR_STATUS
		&& !(state_q == ST_DONE && cmd_q != CMD_SQUELCH) |=> !irq_q) // [R18]
		else $error("status read left irq set");
	AST_CHAIN_NO_IRQ: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		accept && !irq_q && (avs_writedata_i[3:0] == CMD_GAIN_RESET
		|| avs_writedata_i[3:0] == CMD_RSSI_CLEAR) |=> !irq_q) // [R18]
		else $error("chainable command raised irq");
	AST_TEST_PINS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!test_access_o |-> !test_observe_pin_a_o && !test_observe_pin_b_o) // [R19]
		else $error("test pins active without test access");
	AST_TRANSP_ENTRY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		transp_arm_q && sel_s && !sel_prev_q |=> transparent_o) // [R13]
		else $error("transparent not entered on select rise");
	AST_TRIM_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		state_q != ST_RUN |=> $stable(trim_q)) // [R8]
		else $error("trim moved outside calibration");
endmodule : rdce_top

//--- test/rdce_fe_model.sv
// front end model: regulator margin sense and antenna tuning sense
`timescale 1ns/1ps
module rdce_fe_model #(
	parameter logic [5:0] TUNE = 6'h05
) (
	// clock
	input  wire logic        ref_clk_i,
	// levels from the executor and the bench
	input  wire logic [12:0] reg_setting_i,
	input  wire logic [12:0] vdd_mv_i,
	input  wire logic [5:0]  trim_i,
	// sensed levels back to the executor
	output logic             reg_ok_o,
	output logic             ant_in_tune_o
);
	// regulated rail must sit 250 mV under the supply; tank tunes at TUNE
	always_ff @(posedge ref_clk_i) begin
		reg_ok_o      <= ({1'b0, reg_setting_i} + 14'h00FA) <= {1'b0, vdd_mv_i};
		ant_in_tune_o <= trim_i >= TUNE;
	end
endmodule : rdce_fe_model

//--- test/testbench.sv
// self-checking bench of the direct command executor
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("Error t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
	import rdce_pkg::*;
	localparam int          SH = 20;
	localparam logic [31:0] EN = 32'h0000_0080;
	logic        clk, rst, rd, wr, osc, tx, rx, ract, ss, rok, tune;
	logic        wreq, irq, chain, sq, rclr, transp, tacc, toa, tob;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, r;
	logic [7:0]  adc;
	logic [12:0] regset, vdd;
	logic [5:0]  trim;
	logic [2:0]  route;
	int          errors, compares;
	// executor under test, long counts shortened
	rdce_top #(.SQUELCH_CYC(SH), .REG_STEP_CYC(SH), .CALMOD_CYC(SH),
		.CALANT_CYC(SH), .CALCAP_CYC(SH), .MEASCAP_CYC(SH)) i_dut (
		.ref_clk_i(clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .osc_stable_i(osc), .tx_on_i(tx), .rx_en_i(rx),
		.receive_active_i(ract), .spi_select_i(ss), .reg_ok_i(rok),
		.ant_in_tune_i(tune), .adc_value_i(adc), .irq_o(irq), .chain_ok_o(chain),
		.reg_setting_o(regset), .antenna_trim_pins_o(trim), .adc_route_o(route),
		.squelch_o(sq), .rssi_clear_o(rclr), .transparent_o(transp),
		.test_access_o(tacc), .test_observe_pin_a_o(toa), .test_observe_pin_b_o(tob));
	// analog side of the front end
	rdce_fe_model i_fe (.ref_clk_i(clk), .reg_setting_i(regset), .vdd_mv_i(vdd),
		.trim_i(trim), .reg_ok_o(rok), .ant_in_tune_o(tune));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// bus write, held until waitrequest is seen low
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		wr <= 1'b0;
	endtask : wr_reg
	// bus read; data taken at the edge where waitrequest is seen low
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		r = rdata;
		rd <= 1'b0;
	endtask : rd_reg
	task automatic cmd(input logic [3:0] c);
		wr_reg(ADDR_CMD, {28'h0, c});
	endtask : cmd
	// bounded wait for the completion flag, then clear it
	task automatic wait_irq(input int n, input logic e);
		for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clk);
		`CHK(irq, e)
		rd_reg(ADDR_STATUS);
		`CHK(r[1:0], {1'b0, e})
		@(posedge clk);
		`CHK(irq, 1'b0)
	endtask : wait_irq
	task automatic t_reject();
		logic [3:0] g[9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hB, 4'hD};
		`CHK(regset, 13'h0D48)
		rd_reg(ADDR_CTRL);
		`CHK(r, CTRL_RESET)
		foreach (g[i]) begin
			cmd(g[i]);
			wait_irq(30, 1'b0);
		end
		`CHK(regset, 13'h0D48)
		`CHK(transp, 1'b0)
	endtask : t_reject
	task automatic t_phase();
		logic [7:0] v[4] = '{8'hFF, 8'h80, 8'h1F, 8'h00};
		wr_reg(ADDR_CTRL, EN);
		foreach (v[i]) begin
			@(posedge clk);
			adc <= v[i];
			repeat (4) @(posedge clk);
			cmd(CMD_MEAS_PHASE);
			repeat (3) @(posedge clk);
			`CHK(chain, 1'b0)
			wait_irq(3000, 1'b1);
			rd_reg(ADDR_RESULT);
			`CHK(r[7:0], v[i])
		end
	endtask : t_phase
	task automatic t_squelch();
		@(posedge clk);
		tx <= 1'b1;
		rx <= 1'b1;
		repeat (4) @(posedge clk);
		cmd(CMD_SQUELCH);
		repeat (4) @(posedge clk);
		`CHK(sq, 1'b1)
		cmd(CMD_GAIN_RESET);
		repeat (4) @(posedge clk);
		`CHK(sq, 1'b0)
		`CHK(chain, 1'b1)
		wait_irq(SH + 10, 1'b0);
		cmd(CMD_SQUELCH);
		wait_irq(SH + 10, 1'b0);
		`CHK(sq, 1'b0)
		@(posedge clk);
		tx <= 1'b0;
		repeat (4) @(posedge clk);
		cmd(CMD_SQUELCH);
		repeat (4) @(posedge clk);
		`CHK(sq, 1'b0)
	endtask : t_squelch
	task automatic t_reg();
		wr_reg(ADDR_CTRL, EN | 32'h0000_0100);
		cmd(CMD_REG_ADJUST);
		wait_irq(40, 1'b0);
		`CHK(regset, 13'h0D48)
		vdd <= 13'h137E;
		wr_reg(ADDR_CTRL, EN | 32'h0000_0200);
		cmd(CMD_REG_ADJUST);
		repeat (4) @(posedge clk);
		`CHK(regset, REG5_MAX)
		wait_irq(SH * 30, 1'b1);
		`CHK(regset, REG5_MAX - 3 * REG5_STEP)
		vdd <= 13'h07D0;
		wr_reg(ADDR_CTRL, EN);
		cmd(CMD_REG_ADJUST);
		wait_irq(SH * 30, 1'b1);
		`CHK(regset, REG3_MIN)
	endtask : t_reg
	task automatic t_cal();
		logic [3:0] c[4] = '{CMD_CAL_MOD, CMD_CAL_ANT, CMD_MEAS_CAP, CMD_MEAS_AMP};
		adc <= 8'h3C;
		wr_reg(ADDR_CTRL, EN | 32'h0100_0000);
		cmd(CMD_CAL_CAPS);
		wait_irq(60, 1'b0);
		wr_reg(ADDR_CTRL, EN);
		cmd(CMD_CAL_CAPS);
		wait_irq(60, 1'b1);
		foreach (c[i]) begin
			cmd(c[i]);
			wait_irq(3000, 1'b1);
		end
		rd_reg(ADDR_CTRL);
		`CHK(r[23:16], 8'h3C)
		`CHK(trim >= 6'h05, 1'b1)
		cmd(CMD_TEST_ACC);
		repeat (4) @(posedge clk);
		`CHK(tacc, 1'b1)
		`CHK({toa, tob}, 2'b10)
	endtask : t_cal
	task automatic t_supply();
		logic [1:0] s;
		for (int i = 0; i < 4; i++) begin
			s = i[1:0];
			wr_reg(ADDR_CTRL, EN | {20'h0, s, 10'h0});
			cmd(CMD_MEAS_SUP);
			repeat (4) @(posedge clk);
			`CHK(route, {1'b1, s})
			wait_irq(3000, 1'b1);
			rd_reg(ADDR_RESULT);
			`CHK(r[7:0], adc)
		end
	endtask : t_supply
	task automatic t_rssi_transp();
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		ract <= 1'b1;
		repeat (8) @(negedge clk) seen |= rclr;
		`CHK(seen, 1'b1)
		seen = 1'b0;
		cmd(CMD_RSSI_CLEAR);
		repeat (8) @(negedge clk) seen |= rclr;
		`CHK(seen, 1'b1)
		`CHK(chain, 1'b1)
		wait_irq(20, 1'b0);
		// select pulses high for 40 ns, each entry armed afresh
		repeat (2) begin
			cmd(CMD_TRANSP);
			@(posedge clk);
			ss <= 1'b1;
			repeat (4) @(posedge clk);
			`CHK(transp, 1'b1)
			ss <= 1'b0;
			repeat (4) @(posedge clk);
			`CHK(transp, 1'b0)
		end
		ss <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(transp, 1'b0)
		ss <= 1'b0;
	endtask : t_rssi_transp
	task automatic print_verdict();
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	// watchdog against a hung wait
	initial begin
		#500_000;
		errors++;
		print_verdict();
	end
	// main sequence
	initial begin
		{rst, osc} = 2'b11;
		{rd, wr, tx, rx, ract, ss} = 6'h00;
		{addr, wdata, adc, vdd} = {4'h0, 32'h0, 8'h5A, 13'h137E};
		errors = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reject();
		t_phase();
		t_squelch();
		t_reg();
		t_cal();
		t_supply();
		t_rssi_transp();
		print_verdict();
	end
endmodule : testbench
